// ===== hdl/iswc_cfg.svh
`ifndef ISWC_CFG_SVH
`define ISWC_CFG_SVH

// ==========================================================================
// Interrupt source positions in the flag and mask words.
`define ISWC_NUM_SRC 5
`define ISWC_SRC_TIMER0 0
`define ISWC_SRC_TIMER1 1
`define ISWC_SRC_PORTB 2
`define ISWC_SRC_EXT 3
`define ISWC_SRC_WDT 4

// ==========================================================================
// Fetch vectors and program counter width.
`define ISWC_PC_WIDTH 12
`define ISWC_HW_VECTOR 12'h008
`define ISWC_SW_VECTOR 12'h001

// ==========================================================================
// Timer wrap detection values.
`define ISWC_TIMER_TOP 8'hff
`define ISWC_TIMER_ZERO 8'h00

// ==========================================================================
// Configuration word layout.
`define ISWC_CFG_WIDTH 14
`define ISWC_CFG_OSC_LSB 0
`define ISWC_CFG_FREQ_LSB 3
`define ISWC_CFG_WDT_ON 6
`define ISWC_CFG_WDT_RST 7
`define ISWC_CFG_CLK4 8

// ==========================================================================
// Reset values of the cause bits and of the flag and mask words.
`define ISWC_PD_RESET 1'b1
`define ISWC_TO_RESET 1'b1
`define ISWC_FLAGS_RESET 5'h00
`define ISWC_MASK_RESET 5'h00

`endif

// ===== hdl/iswc_pkg.sv
package iswc_pkg;

  // Oscillator modes selected by the low configuration field.
  typedef enum logic [2:0] {
    resistor_only_osc_mode = 3'b000,
    internal_rc_osc_mode = 3'b001,
    unused_osc_mode = 3'b010,
    internal_rc_io_osc_mode = 3'b011,
    low_freq_crystal_mode = 3'b100,
    standard_crystal_mode = 3'b101,
    high_freq_crystal_mode = 3'b110,
    external_rc_osc_mode = 3'b111
  } iswc_osc_type;

  // Internal or resistor oscillator frequency codes.
  typedef enum logic [2:0] {
    freq_20mhz = 3'b000,
    freq_16mhz = 3'b001,
    freq_8mhz = 3'b010,
    freq_4mhz = 3'b011,
    freq_2mhz = 3'b100,
    freq_1mhz = 3'b101,
    freq_455khz = 3'b110,
    freq_32khz = 3'b111
  } iswc_freq_type;

  // Power state of the core.
  typedef enum logic [1:0] {
    st_run = 2'b00,
    st_sleep = 2'b01,
    st_wake = 2'b10
  } iswc_state_type;

endpackage

// ===== hdl/iswc_cfg_if.sv
`timescale 1ns/1ns
`default_nettype none
`include "iswc_cfg.svh"

// Configuration word and its decoded fields.
interface iswc_cfg_if;
  logic [`ISWC_CFG_WIDTH-1:0] config_word;
  iswc_pkg::iswc_osc_type osc_mode;
  iswc_pkg::iswc_freq_type rc_freq_field;
  logic watchdog_on_bit;
  logic watchdog_reset_select;
  logic four_period_cycle;
  logic clkout_enable;

  modport decoder (
    input config_word,
    output osc_mode, rc_freq_field, watchdog_on_bit, watchdog_reset_select,
    output four_period_cycle, clkout_enable
  );

  modport user (
    output config_word,
    input osc_mode, rc_freq_field, watchdog_on_bit, watchdog_reset_select,
    input four_period_cycle, clkout_enable
  );
endinterface

`default_nettype wire

// ===== hdl/iswc_sync.sv
`timescale 1ns/1ns
`default_nettype none

// Three-stage pin synchroniser; a bit changes once stages two and three agree.
module iswc_sync #(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] mid_q;
  logic [WIDTH-1:0] late_q;

  // The first stage feeds only the second stage.
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      meta_q <= RESET_VAL;
      mid_q <= RESET_VAL;
      late_q <= RESET_VAL;
    end
    else
    begin
      meta_q <= async_in;
      mid_q <= meta_q;
      late_q <= mid_q;
    end
  end

  // Each bit follows only when the two settled stages agree.
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      always_ff @(posedge mclk)
      begin
        if (reset)
          sync_out[i] <= RESET_VAL[i];
        else if (mid_q[i] == late_q[i])
          sync_out[i] <= late_q[i];
      end
    end
  endgenerate

endmodule

`default_nettype wire

// ===== hdl/iswc_cfg_decode.sv
`timescale 1ns/1ns
`default_nettype none
`include "iswc_cfg.svh"

// Splits the one-time configuration word into its fields.
module iswc_cfg_decode (
  iswc_cfg_if.decoder cfg
);

  // Oscillator mode, frequency code, watchdog options and cycle length.
  always_comb
  begin
    cfg.osc_mode = iswc_pkg::iswc_osc_type'(cfg.config_word[`ISWC_CFG_OSC_LSB +: 3]);
    cfg.rc_freq_field = iswc_pkg::iswc_freq_type'(cfg.config_word[`ISWC_CFG_FREQ_LSB +: 3]);
    cfg.watchdog_on_bit = cfg.config_word[`ISWC_CFG_WDT_ON];
    cfg.watchdog_reset_select = cfg.config_word[`ISWC_CFG_WDT_RST];
    cfg.four_period_cycle = cfg.config_word[`ISWC_CFG_CLK4];
    // Only the resistor-only, internal RC and external RC modes drive the clock pin.
    cfg.clkout_enable = (cfg.osc_mode == iswc_pkg::resistor_only_osc_mode)
      || (cfg.osc_mode == iswc_pkg::internal_rc_osc_mode)
      || (cfg.osc_mode == iswc_pkg::external_rc_osc_mode);
  end

endmodule

`default_nettype wire

// ===== hdl/iswc_top.sv
// What this block does
// - Global enable gates all interrupt requests.
// - Per-source mask bit blocks its interrupt.
// - Hardware interrupt fetches from address 008h.
// - Software interrupt instruction fetches from 001h.
// - Flags set regardless of masks, except port change.
// - Flag read returns flags AND mask.
// - External pin edge, selectable polarity, sets flag.
// - Timer0 FFh to 00h wrap sets flag.
// - Timer1 FFh to 00h wrap sets flag.
// - Enabled port B pin change sets flag.
// - No change detect on outputs or external pin.
// - Watchdog timeout sets flag in interrupt mode.
// - Sleep clears power-down, sets timeout, clears watchdog.
// - Sleep ends on reset, watchdog, enabled pin events.
// - Reset pin or watchdog reset; cause bits.
// - Wake vectors if global enable and an enabled flag is pending, else resumes.
// - Config bits 2:0 select oscillator mode.
// - Config bits 5:3 select RC frequency.
// - Config bits 6,7 watchdog enable and reset.
// - Config bit 8 selects instruction cycle length.
// - External pin function disables its change detect.
`timescale 1ns/1ns
`default_nettype none
`include "iswc_cfg.svh"

module iswc_top (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [`ISWC_CFG_WIDTH-1:0] config_word,
  output iswc_pkg::iswc_osc_type osc_mode,
  output iswc_pkg::iswc_freq_type rc_freq_field,
  output logic watchdog_on_bit,
  output logic watchdog_reset_select,
  output logic four_period_cycle,
  output logic clkout_enable,
  input wire logic global_irq_on_instr,
  input wire logic global_irq_off_instr,
  input wire logic return_and_unmask_instr,
  input wire logic sw_irq_instr,
  input wire logic sleep_instr,
  input wire logic clear_watchdog_instr,
  input wire logic fetch_boundary,
  input wire logic flag_wr_en,
  input wire logic [`ISWC_NUM_SRC-1:0] flag_wr_data,
  input wire logic mask_wr_en,
  input wire logic [`ISWC_NUM_SRC-1:0] mask_wr_data,
  output logic [`ISWC_NUM_SRC-1:0] irq_flag_reg,
  output logic [`ISWC_NUM_SRC-1:0] irq_mask_reg,
  input wire logic ext_edge_select,
  input wire logic ext_irq_select_bit,
  input wire logic [7:0] pin_change_enable_reg,
  input wire logic [7:0] portb_is_output,
  input wire logic [7:0] portb_pins,
  input wire logic portb_read,
  input wire logic [7:0] timer_zero_count,
  input wire logic [7:0] timer_one_count,
  input wire logic watchdog_timeout,
  input wire logic reset_pin_n,
  output logic vector_load,
  output logic [`ISWC_PC_WIDTH-1:0] vector_addr,
  output logic resume_after_sleep,
  output logic sleeping,
  output logic osc_driver_off,
  output logic hold_io,
  output logic watchdog_clear,
  output logic device_reset_req,
  output logic power_down_bit,
  output logic timeout_bit,
  output logic global_irq_enable
);

  // ========================================================================
  // Configuration decode
  // ========================================================================

  iswc_cfg_if cfg_bus ();

  // The configuration word is static after power-up, so no register sits here.
  assign cfg_bus.config_word = config_word;

  iswc_cfg_decode u_cfg_decode (
    .cfg (cfg_bus.decoder)
  );

  // Decoded fields leave the block directly for the clock and pin logic.
  assign osc_mode = cfg_bus.osc_mode;
  assign rc_freq_field = cfg_bus.rc_freq_field;
  assign watchdog_on_bit = cfg_bus.watchdog_on_bit;
  assign watchdog_reset_select = cfg_bus.watchdog_reset_select;
  assign four_period_cycle = cfg_bus.four_period_cycle;
  assign clkout_enable = cfg_bus.clkout_enable;

  // ========================================================================
  // Pin synchronisers
  // ========================================================================

  logic [7:0] portb_s;
  logic reset_pin_n_s;

  iswc_sync #(
    .WIDTH (8),
    .RESET_VAL (8'h00)
  ) u_portb_sync (
    .mclk (mclk),
    .reset (reset),
    .async_in (portb_pins),
    .sync_out (portb_s)
  );

  // The reset pin idles high, so its synchroniser resets to the idle level.
  iswc_sync #(
    .WIDTH (1),
    .RESET_VAL (1'b1)
  ) u_rstpin_sync (
    .mclk (mclk),
    .reset (reset),
    .async_in (reset_pin_n),
    .sync_out (reset_pin_n_s)
  );

  // ========================================================================
  // Device reset causes
  // ========================================================================

  logic wdt_reset_evt;
  logic wdt_irq_evt;
  logic dev_rst;
  logic clear_all;

  // Watchdog time-out is either a reset or an interrupt, never both.
  assign wdt_reset_evt = watchdog_timeout && cfg_bus.watchdog_on_bit
    && cfg_bus.watchdog_reset_select;
  assign wdt_irq_evt = watchdog_timeout && cfg_bus.watchdog_on_bit
    && !cfg_bus.watchdog_reset_select;
  assign dev_rst = !reset_pin_n_s || wdt_reset_evt;
  assign clear_all = reset || dev_rst;

  // Reset request to the rest of the chip, held while a cause is present.
  always_ff @(posedge mclk)
  begin
    if (reset)
      device_reset_req <= 1'b0;
    else
      device_reset_req <= dev_rst;
  end

  // ========================================================================
  // Event detection
  // ========================================================================

  logic [7:0] tmr0_prev_q;
  logic [7:0] tmr1_prev_q;
  logic ext_prev_q;
  logic [7:0] portb_ref_q;
  logic tmr0_evt;
  logic tmr1_evt;
  logic ext_evt;
  logic [7:0] change_eligible;
  logic portb_evt;

  // Previous values for wrap and edge detection.
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      tmr0_prev_q <= 8'h00;
      tmr1_prev_q <= 8'h00;
      ext_prev_q <= 1'b0;
    end
    else
    begin
      tmr0_prev_q <= timer_zero_count;
      tmr1_prev_q <= timer_one_count;
      ext_prev_q <= portb_s[0];
    end
  end

  // Timer wraps are seen as the exact pair of values on consecutive cycles.
  assign tmr0_evt = (tmr0_prev_q == `ISWC_TIMER_TOP)
    && (timer_zero_count == `ISWC_TIMER_ZERO);
  assign tmr1_evt = (tmr1_prev_q == `ISWC_TIMER_TOP)
    && (timer_one_count == `ISWC_TIMER_ZERO);

  // Edge select high picks the rising edge, low picks the falling edge.
  assign ext_evt = ext_irq_select_bit && (ext_prev_q != portb_s[0])
    && (portb_s[0] == ext_edge_select);

  // The reference state is taken whenever software reads the port.
  always_ff @(posedge mclk)
  begin
    if (reset)
      portb_ref_q <= 8'h00;
    else if (portb_read)
      portb_ref_q <= portb_s;
  end

  // Outputs and the external interrupt pin are left out of change detection.
  assign change_eligible = pin_change_enable_reg & ~portb_is_output
    & ~{7'h00, ext_irq_select_bit};

  // A mismatch keeps asserting until the port is read again.
  assign portb_evt = |((portb_s ^ portb_ref_q) & change_eligible);

  // ========================================================================
  // Flags and masks
  // ========================================================================

  logic [`ISWC_NUM_SRC-1:0] flags_q;
  logic [`ISWC_NUM_SRC-1:0] flags_d;
  logic [`ISWC_NUM_SRC-1:0] mask_q;
  logic [`ISWC_NUM_SRC-1:0] mask_d;
  logic [`ISWC_NUM_SRC-1:0] set_vec;
  logic irq_pending;

  // Hardware events beat a software write in the same cycle.
  always_comb
  begin
    set_vec = '0;
    set_vec[`ISWC_SRC_TIMER0] = tmr0_evt;
    set_vec[`ISWC_SRC_TIMER1] = tmr1_evt;
    set_vec[`ISWC_SRC_EXT] = ext_evt;
    set_vec[`ISWC_SRC_WDT] = wdt_irq_evt;
    set_vec[`ISWC_SRC_PORTB] = portb_evt && mask_q[`ISWC_SRC_PORTB];
    flags_d = (flag_wr_en ? flag_wr_data : flags_q) | set_vec;
    mask_d = mask_wr_en ? mask_wr_data : mask_q;
  end

  // Flags and masks are cleared by power-up and by any device reset.
  always_ff @(posedge mclk)
  begin
    if (clear_all)
    begin
      flags_q <= `ISWC_FLAGS_RESET;
      mask_q <= `ISWC_MASK_RESET;
    end
    else
    begin
      flags_q <= flags_d;
      mask_q <= mask_d;
    end
  end

  // The readable flag word is the masked view, registered for a clean output.
  always_ff @(posedge mclk)
  begin
    if (clear_all)
      irq_flag_reg <= `ISWC_FLAGS_RESET;
    else
      irq_flag_reg <= flags_d & mask_d;
  end

  assign irq_mask_reg = mask_q;

  // Any enabled flag requests; the service routine polls to find which.
  assign irq_pending = |(flags_q & mask_q);

  // ========================================================================
  // Global enable and vectoring
  // ========================================================================

  iswc_pkg::iswc_state_type state_q;
  logic take_irq;
  logic wake_evt;
  logic wake_vector;
  logic wake_resume;

  // A pending request is only taken at an instruction boundary while running.
  assign take_irq = global_irq_enable && irq_pending && fetch_boundary
    && (state_q == iswc_pkg::st_run);

  // Entering the handler closes the gate so a stale flag cannot re-enter at once.
  always_ff @(posedge mclk)
  begin
    if (clear_all)
      global_irq_enable <= 1'b0;
    else if (take_irq || wake_vector || sw_irq_instr || global_irq_off_instr)
      global_irq_enable <= 1'b0;
    else if (global_irq_on_instr || return_and_unmask_instr)
      global_irq_enable <= 1'b1;
  end

  // One load pulse per redirect; software vector takes precedence.
  always_ff @(posedge mclk)
  begin
    if (clear_all)
    begin
      vector_load <= 1'b0;
      vector_addr <= `ISWC_PC_WIDTH'(0);
    end
    else if (sw_irq_instr)
    begin
      vector_load <= 1'b1;
      vector_addr <= `ISWC_SW_VECTOR;
    end
    else if (take_irq || wake_vector)
    begin
      vector_load <= 1'b1;
      vector_addr <= `ISWC_HW_VECTOR;
    end
    else
      vector_load <= 1'b0;
  end

  // ========================================================================
  // Sleep and wake-up
  // ========================================================================

  // Watchdog interrupt wakes whatever its mask; pin events wake only if enabled.
  assign wake_evt = wdt_irq_evt
    || (ext_evt && mask_q[`ISWC_SRC_EXT])
    || (portb_evt && mask_q[`ISWC_SRC_PORTB]);

  // The wake cycle lets the waking flag land before the branch decision.
  assign wake_vector = (state_q == iswc_pkg::st_wake)
    && global_irq_enable && irq_pending;
  assign wake_resume = (state_q == iswc_pkg::st_wake) && !wake_vector;

  // Power state machine; resets also end sleep.
  always_ff @(posedge mclk)
  begin
    if (clear_all)
      state_q <= iswc_pkg::st_run;
    else
    begin
      case (state_q)
        iswc_pkg::st_run:
        begin
          if (sleep_instr)
            state_q <= iswc_pkg::st_sleep;
        end
        iswc_pkg::st_sleep:
        begin
          if (wake_evt)
            state_q <= iswc_pkg::st_wake;
        end
        default:
          state_q <= iswc_pkg::st_run;
      endcase
    end
  end

  // Continue after the sleep instruction when no vector is taken.
  always_ff @(posedge mclk)
  begin
    if (clear_all)
      resume_after_sleep <= 1'b0;
    else
      resume_after_sleep <= wake_resume;
  end

  // The oscillator stays off and pins frozen for as long as the core sleeps.
  assign sleeping = (state_q == iswc_pkg::st_sleep);
  assign osc_driver_off = sleeping;
  assign hold_io = sleeping;

  // The watchdog is cleared but keeps running; sleep and its clear instruction pulse it.
  always_ff @(posedge mclk)
  begin
    if (reset)
      watchdog_clear <= 1'b0;
    else
      watchdog_clear <= (sleep_instr && state_q == iswc_pkg::st_run)
        || clear_watchdog_instr;
  end

  // ========================================================================
  // Reset cause bits
  // ========================================================================

  // Only power-up initialises these, so they survive the resets they report.
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      power_down_bit <= `ISWC_PD_RESET;
      timeout_bit <= `ISWC_TO_RESET;
    end
    else if (wdt_reset_evt)
      timeout_bit <= 1'b0;
    else if (sleep_instr && state_q == iswc_pkg::st_run)
    begin
      power_down_bit <= 1'b0;
      timeout_bit <= 1'b1;
    end
    else if (clear_watchdog_instr)
    begin
      power_down_bit <= 1'b1;
      timeout_bit <= 1'b1;
    end
  end

endmodule

`default_nettype wire

// ===== tb/iswc_core_model.sv
`timescale 1ns/1ns
`default_nettype none

// ==========================================================================
// Fetch side of the core: accepts redirects and follows the vector.
module iswc_core_model (
  input wire logic mclk,
  input wire logic reset,
  input wire logic stall,
  input wire logic vector_load,
  input wire logic [11:0] vector_addr,
  output logic fetch_boundary,
  output logic [11:0] pc_q,
  output logic [7:0] loads_q
);
  // A busy core reports no instruction boundary, so a stall delays a hardware take.
  assign fetch_boundary = !stall;

  // The next fetch comes from whatever vector the block hands over.
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      pc_q <= 12'h000;
      loads_q <= 8'h00;
    end
    else if (vector_load)
    begin
      pc_q <= vector_addr;
      loads_q <= loads_q + 8'h01;
    end
  end
endmodule

`default_nettype wire

// ===== tb/iswc_top_asserts.sv
`timescale 1ns/1ns
`default_nettype none

// ==========================================================================
// Port checker of the interrupt, sleep and configuration block.
module iswc_top_asserts (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [13:0] config_word,
  input var iswc_pkg::iswc_osc_type osc_mode,
  input wire logic clkout_enable,
  input wire logic global_irq_on_instr,
  input wire logic global_irq_off_instr,
  input wire logic return_and_unmask_instr,
  input wire logic sw_irq_instr,
  input wire logic sleep_instr,
  input wire logic fetch_boundary,
  input wire logic [4:0] irq_flag_reg,
  input wire logic [4:0] irq_mask_reg,
  input wire logic [7:0] timer_zero_count,
  input wire logic watchdog_timeout,
  input wire logic vector_load,
  input wire logic [11:0] vector_addr,
  input wire logic sleeping,
  input wire logic osc_driver_off,
  input wire logic hold_io,
  input wire logic watchdog_clear,
  input wire logic device_reset_req,
  input wire logic power_down_bit,
  input wire logic timeout_bit,
  input wire logic global_irq_enable
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);

  hw_vector_a: assert property (
    global_irq_enable && |irq_flag_reg && fetch_boundary && !sleeping && !sw_irq_instr
    && !global_irq_off_instr && !device_reset_req && !watchdog_timeout
    |=> vector_load && vector_addr == 12'h008 && !global_irq_enable)
    else $error("hardware take did not vector");
  sw_vector_a: assert property (
    sw_irq_instr && !device_reset_req && !watchdog_timeout
    |=> vector_load && vector_addr == 12'h001) else $error("software vector wrong");
  irq_off_a: assert property (
    global_irq_off_instr |=> !global_irq_enable) else $error("enable survived off");
  irq_on_a: assert property (
    $rose(global_irq_enable) |-> $past(global_irq_on_instr) || $past(return_and_unmask_instr))
    else $error("enable rose without cause");
  vector_cause_a: assert property (
    $rose(vector_load) |-> $past(global_irq_enable) || $past(sw_irq_instr))
    else $error("vector without enable");
  flag_and_a: assert property (
    (irq_flag_reg & ~irq_mask_reg) == 5'h00) else $error("masked flag visible");
  timer_wrap_a: assert property (
    $past(timer_zero_count) == 8'hff && timer_zero_count == 8'h00 && !device_reset_req
    && !watchdog_timeout |=> irq_flag_reg[0] == irq_mask_reg[0])
    else $error("timer wrap flag missing");
  sleep_entry_a: assert property (
    sleep_instr && !sleeping && !device_reset_req && !watchdog_timeout
    |=> sleeping && !power_down_bit && timeout_bit && watchdog_clear)
    else $error("sleep entry wrong");
  sleep_hold_a: assert property (
    sleeping |-> osc_driver_off && hold_io) else $error("sleep outputs wrong");
  osc_decode_a: assert property (
    osc_mode == config_word[2:0] && clkout_enable == (config_word[2:0] == 3'h0
    || config_word[2:0] == 3'h1 || config_word[2:0] == 3'h7)) else $error("osc decode wrong");

  // Main scenarios reached.
  cover property (vector_load && vector_addr == 12'h008);
  cover property (sleeping ##1 !sleeping);
  cover property (device_reset_req && !timeout_bit);
endmodule

`default_nettype wire

// ===== tb/irq_sleep_wake_control_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "iswc_cfg.svh"

// ==========================================================================
// Comparison helper: counts every check and reports each mismatch.
`define CHK(what, exp, got) \
  begin \
    checked++; \
    if ((got) !== (exp)) \
    begin \
      fails++; \
      $display("unexpected %s expected %0h seen %0h", what, exp, got); \
    end \
  end

module irq_sleep_wake_control_tb;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic [13:0] config_word = 14'h3fff;
  logic global_irq_on_instr = 1'b0, global_irq_off_instr = 1'b0, return_and_unmask_instr = 1'b0;
  logic sw_irq_instr = 1'b0, sleep_instr = 1'b0, clear_watchdog_instr = 1'b0;
  logic flag_wr_en = 1'b0, mask_wr_en = 1'b0, portb_read = 1'b0, watchdog_timeout = 1'b0;
  logic [4:0] flag_wr_data = 5'h00, mask_wr_data = 5'h00;
  logic ext_edge_select = 1'b0, ext_irq_select_bit = 1'b0, reset_pin_n = 1'b1, stall = 1'b0;
  logic [7:0] pin_change_enable_reg = 8'h00, portb_is_output = 8'h00, portb_pins = 8'h00;
  logic [7:0] timer_zero_count = 8'h00, timer_one_count = 8'h00, core_loads;
  iswc_pkg::iswc_osc_type osc_mode;
  iswc_pkg::iswc_freq_type rc_freq_field;
  logic watchdog_on_bit, watchdog_reset_select, four_period_cycle, clkout_enable, hit;
  logic [4:0] irq_flag_reg, irq_mask_reg;
  logic vector_load, resume_after_sleep, sleeping, osc_driver_off, hold_io, watchdog_clear;
  logic device_reset_req, power_down_bit, timeout_bit, global_irq_enable, fetch_boundary;
  logic [11:0] vector_addr, core_pc;
  int checked = 0;
  int fails = 0;

  iswc_top iswc_top_inst (.*);
  iswc_core_model iswc_core_model_inst (.mclk, .reset, .stall, .vector_load, .vector_addr,
    .fetch_boundary, .pc_q(core_pc), .loads_q(core_loads));

  // Free-running clock at 250 MHz.
  always #2 mclk = ~mclk;

  // One-cycle instruction pulses.
  task automatic instr(input int k);
    @(posedge mclk);
    case (k)
      0: global_irq_on_instr <= 1'b1;
      1: global_irq_off_instr <= 1'b1;
      2: return_and_unmask_instr <= 1'b1;
      3: sw_irq_instr <= 1'b1;
      4: sleep_instr <= 1'b1;
      5: portb_read <= 1'b1;
      default: watchdog_timeout <= 1'b1;
    endcase
    @(posedge mclk);
    {global_irq_on_instr, global_irq_off_instr, return_and_unmask_instr} <= 3'h0;
    {sw_irq_instr, sleep_instr, portb_read, watchdog_timeout} <= 4'h0;
  endtask

  // Writes the mask when m is set, otherwise the stored flags.
  task automatic wr(input logic m, input logic [4:0] v);
    @(posedge mclk);
    {mask_wr_en, flag_wr_en} <= {m, !m};
    {mask_wr_data, flag_wr_data} <= {v, v};
    @(posedge mclk);
    {mask_wr_en, flag_wr_en} <= 2'h0;
  endtask

  // Bounded wait: 0 vector, 1 resume, 2 and up a flag bit.
  task automatic wait_for(input int sel, input int lim);
    hit = 1'b0;
    for (int i = 0; i < lim && hit !== 1'b1; i++)
    begin
      @(negedge mclk);
      hit = (sel == 0) ? vector_load : (sel == 1) ? resume_after_sleep : irq_flag_reg[sel - 2];
    end
  endtask

  task automatic t_cfg();
    for (int i = 0; i < 8; i++)
    begin
      @(posedge mclk) config_word <= {5'h1f, 3'(i), 3'(i), 3'(7 - i)};
      @(negedge mclk);
      `CHK("osc mode", 3'(7 - i), osc_mode)
      `CHK("clock out", (i == 0 || i == 6 || i == 7), clkout_enable)
      `CHK("rc freq", 3'(i), rc_freq_field)
      `CHK("wdt on", i[0], watchdog_on_bit)
      `CHK("wdt reset", i[1], watchdog_reset_select)
      `CHK("cycle length", i[2], four_period_cycle)
    end
    @(posedge mclk) config_word <= 14'h3f7f;
  endtask

  task automatic t_timer();
    @(posedge mclk) {timer_zero_count, timer_one_count} <= 16'hffff;
    @(posedge mclk) {timer_zero_count, timer_one_count} <= 16'h0000;
    repeat (2) @(negedge mclk);
    `CHK("masked read", 5'h00, irq_flag_reg)
    wr(1'b1, 5'h03);
    @(negedge mclk);
    `CHK("raw flags", 5'h03, irq_flag_reg)
    @(posedge mclk) stall <= 1'b1;
    instr(0);
    wait_for(0, 6);
    `CHK("stalled take", 1'b0, hit)
    @(posedge mclk) stall <= 1'b0;
    wait_for(0, 4);
    `CHK("take", 1'b1, hit)
    repeat (3) @(negedge mclk);
    `CHK("one vector", 8'h01, core_loads)
    `CHK("fetch pc", 12'h008, core_pc)
    `CHK("flags kept", 5'h03, irq_flag_reg)
    `CHK("enable dropped", 1'b0, global_irq_enable)
    wr(1'b0, 5'h00);
    instr(2);
    wait_for(0, 4);
    `CHK("no retake", 1'b0, hit)
    `CHK("unmasked", 1'b1, global_irq_enable)
  endtask

  task automatic t_sw();
    instr(3);
    repeat (2) @(negedge mclk);
    `CHK("sw vector", 12'h001, core_pc)
    `CHK("sw enable", 1'b0, global_irq_enable)
  endtask

  task automatic t_pin();
    @(posedge mclk) pin_change_enable_reg <= 8'h02;
    wr(1'b1, 5'h04);
    instr(5);
    @(posedge mclk) portb_pins <= 8'h02;
    wait_for(4, 10);
    `CHK("pin change", 1'b1, hit)
    @(posedge mclk) portb_is_output <= 8'h02;
    instr(5);
    wr(1'b0, 5'h00);
    @(posedge mclk) portb_pins <= 8'h00;
    wait_for(4, 10);
    `CHK("inhibited change", 1'b0, hit)
  endtask

  task automatic t_ext();
    @(posedge mclk) {ext_irq_select_bit, ext_edge_select} <= 2'h3;
    {pin_change_enable_reg, portb_is_output} <= 16'h0100;
    wr(1'b1, 5'h0c);
    instr(5);
    wr(1'b0, 5'h00);
    @(posedge mclk) portb_pins <= 8'h09;
    wait_for(5, 10);
    `CHK("rising edge", 1'b1, hit)
    repeat (4) @(negedge mclk);
    `CHK("ext pin change", 1'b0, irq_flag_reg[2])
    wr(1'b0, 5'h00);
    @(posedge mclk) portb_pins <= 8'h08;
    wait_for(5, 10);
    `CHK("wrong edge", 1'b0, hit)
  endtask

  task automatic t_sleep();
    wr(1'b1, 5'h08);
    instr(0);
    instr(4);
    @(negedge mclk);
    `CHK("asleep", 3'h5, {sleeping, power_down_bit, timeout_bit})
    @(posedge mclk) portb_pins <= 8'h09;
    wait_for(0, 12);
    `CHK("wake vector", 1'b1, hit)
    `CHK("wake addr", 12'h008, vector_addr)
    wr(1'b0, 5'h00);
    instr(1);
    @(posedge mclk) ext_edge_select <= 1'b0;
    instr(4);
    @(posedge mclk) portb_pins <= 8'h08;
    wait_for(1, 12);
    `CHK("resume", 1'b1, hit)
  endtask

  task automatic t_cause();
    @(posedge mclk) reset_pin_n <= 1'b0;
    repeat (6) @(negedge mclk);
    `CHK("pin reset", 2'h2, {device_reset_req, power_down_bit})
    @(posedge mclk) reset_pin_n <= 1'b1;
    repeat (6) @(posedge mclk);
    wr(1'b1, 5'h10);
    instr(6);
    @(negedge mclk);
    `CHK("wdt flag", 1'b1, irq_flag_reg[4])
    @(posedge mclk) config_word <= 14'h3fff;
    instr(6);
    @(negedge mclk);
    `CHK("wdt reset", 2'h2, {device_reset_req, timeout_bit})
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Main sequence after a 16-cycle power-up reset.
  initial
  begin
    repeat (16) @(posedge mclk);
    reset <= 1'b0;
    t_cfg();
    t_timer();
    t_sw();
    t_pin();
    t_ext();
    t_sleep();
    t_cause();
    conclude();
  end

  // A hang ends the run after 5000 cycles.
  initial
  begin
    #20000;
    fails++;
    conclude();
  end
endmodule

bind iswc_top iswc_top_asserts iswc_top_asserts_inst (.*);

`default_nettype wire
